// *** common/monitor_serial_pkg.sv ***
// Constants and types shared by the monitor serial slave port
package monitor_serial_pkg;
   // System clock and bus lockup timeout
   localparam int CLK_HZ = 10_000_000;
   localparam int TIMEOUT_MS = 28;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   // Supported serial clock rates, in Hz
   localparam int SCL_MIN_HZ = 1_000;
   localparam int SCL_FAST_MAX_HZ = 400_000;
   localparam int SCL_HS_MAX_HZ = 2_940_000;
   // Register pointer locations
   localparam logic [7:0] PTR_CONFIG = 8'h00;
   localparam logic [7:0] PTR_SHUNT = 8'h01;
   localparam logic [7:0] PTR_BUS = 8'h02;
   localparam logic [7:0] PTR_POWER = 8'h03;
   localparam logic [7:0] PTR_CURRENT = 8'h04;
   localparam logic [7:0] PTR_CAL = 8'h05;
   // Power-up values
   localparam logic [15:0] CONFIG_RESET = 16'h4127;
   localparam logic [15:0] CAL_RESET = 16'h0000;
   localparam logic [7:0] PTR_RESET = PTR_CONFIG;
   localparam int CONFIG_RST_BIT = 15;
   // Slave address: fixed part, then high and low strap codes
   localparam logic [2:0] ADDR_FIXED = 3'h4;
   localparam logic [1:0] STRAP_GND = 2'h0;
   localparam logic [1:0] STRAP_VS = 2'h1;
   localparam logic [1:0] STRAP_SDA = 2'h2;
   localparam logic [1:0] STRAP_SCL = 2'h3;
   // Scaling: current divides by 2048, power by 20000
   localparam int CUR_SHIFT = 11;
   localparam logic [31:0] POWER_DIV = 32'h0000_4E20;
   // Byte framing and write byte slots
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] IDX_PTR = 2'h0;
   localparam logic [1:0] IDX_MSB = 2'h1;
   localparam logic [1:0] IDX_LSB = 2'h2;
   localparam logic [1:0] IDX_DONE = 2'h3;
   // Port protocol states
   typedef enum logic [2:0] {
      st_idle, st_addr, st_addr_ack, st_rx, st_rx_ack, st_tx, st_tx_ack
   } port_state_t;
endpackage

// *** rtl/monitor_serial_slave_port.sv ***
// Two-wire slave port with pointer, registers and result scaling
//
// What this block does
// - No valid current or power before calibration
// - Registers volatile, defaults give continuous conversion
// - Start is data falling while clock high
// - Address bits sampled on rise, last is direction
// - Matching address acked low on ninth pulse
// - Eight bits plus ack; changes in low
// - Stop is data rising while clock high
// - Timeout releases bus, abandons stalled transaction
// - Address byte is seven bits plus direction
// - Straps resampled at every transaction
// - Four level straps give address 100HHLL
// - Acts only as slave, never initiates
// - Clock rates 1 kHz to 2.94 MHz
// - Sixteen bit values sent high byte first
// - First write byte loads register pointer
// - Next two bytes stored, each acknowledged
// - Pointer only write selects register for read
// - Read sends high byte, then low byte
// - Read ends on nack, start or stop
// - Pointer kept between transactions until rewritten
// - Current is shunt times calibration over 2048
// - Power is current times bus over 20000
// - Current and power zero until calibrated
`timescale 1ns/10ps
module monitor_serial_slave_port
   import monitor_serial_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [1:0] address_strap_low,
   input wire logic [1:0] address_strap_high,
   input wire logic [15:0] shunt_voltage,
   input wire logic [15:0] bus_voltage,
   output logic [15:0] config_word,
   output logic busy
);

   localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);

   // Pin synchronisers plus one history stage for edge finding
   logic scl_s1_q, scl_s2_q, scl_p_q;
   logic sda_s1_q, sda_s2_q, sda_p_q;
   logic [1:0] strap_lo_s1_q, strap_lo_s2_q;
   logic [1:0] strap_hi_s1_q, strap_hi_s2_q;
   // Address latched at each start
   logic [6:0] my_addr_q, my_addr_d;
   // Protocol state
   port_state_t state_q, state_d;
   logic [3:0] bit_q, bit_d;         // Bits seen in the current byte
   logic [7:0] shift_q, shift_d;     // Received bits
   logic [7:0] tx_q, tx_d;           // Byte being sent
   logic [1:0] idx_q, idx_d;         // Write byte slot
   logic [7:0] hold_q, hold_d;       // High byte of a write
   logic sda_low_q, sda_low_d;       // Pulling the data line low
   logic rw_q, rw_d;                 // Direction of this transaction
   logic nack_q, nack_d;             // Master declined last byte
   logic lsb_q, lsb_d;               // Next read byte is the low one
   // Register file
   logic [7:0] ptr_q, ptr_d;
   logic [15:0] cfg_q, cfg_d;
   logic [15:0] cal_q, cal_d;
   logic [15:0] current_q, power_q;
   logic [TMO_W-1:0] tmo_q;

   // Line events from the synchronised levels
   wire scl_rise = scl_s2_q & ~scl_p_q;
   wire scl_fall = ~scl_s2_q & scl_p_q;
   wire scl_high = scl_s2_q & scl_p_q;
   wire start_det = scl_high & sda_p_q & ~sda_s2_q;
   wire stop_det = scl_high & ~sda_p_q & sda_s2_q;
   wire byte_end = (bit_q == BITS_PER_BYTE);
   wire shifting = (state_q == st_addr) || (state_q == st_rx) ||
                   (state_q == st_tx);
   wire tmo_hit = (state_q != st_idle) &&
                  (tmo_q == TMO_W'(TIMEOUT_CYCLES - 1));
   wire [6:0] strap_addr =
      {ADDR_FIXED, strap_hi_s2_q, strap_lo_s2_q};
   wire [15:0] wr_word = {hold_q, shift_q};

   // Register read selection; unmapped pointers read zero
   function automatic logic [15:0] read_reg(
      input logic [7:0] ptr,
      input logic [15:0] cfg,
      input logic [15:0] shunt,
      input logic [15:0] bus,
      input logic [15:0] pwr,
      input logic [15:0] cur,
      input logic [15:0] cal
   );
      logic [15:0] val;
      val = 16'h0000;
      unique case (ptr)
         PTR_CONFIG: val = cfg;
         PTR_SHUNT: val = shunt;
         PTR_BUS: val = bus;
         PTR_POWER: val = pwr;
         PTR_CURRENT: val = cur;
         PTR_CAL: val = cal;
         default: val = 16'h0000;
      endcase
      return val;
   endfunction

   // Word at the pointer, sent high byte first
   wire [15:0] rd_word = read_reg(ptr_q, cfg_q, shunt_voltage,
      bus_voltage, power_q, current_q, cal_q);

   // Current scaling: signed shunt times unsigned calibration
   wire signed [32:0] cur_prod =
      $signed(shunt_voltage) * $signed({1'b0, cal_q});
   wire [15:0] cur_next = cur_prod[CUR_SHIFT +: 16];
   // Power works on the magnitude of the current
   wire [15:0] cur_mag = current_q[15] ? 16'(-current_q) : current_q;
   wire [31:0] pow_prod = cur_mag * bus_voltage;
   wire [31:0] pow_quot = pow_prod / POWER_DIV;
   wire cal_zero = (cal_q == CAL_RESET);

   // The port only ever pulls data low; the clock is never driven
   assign sda_out = 1'b0;
   assign sda_oe_n = ~sda_low_q;
   assign config_word = cfg_q;
   assign busy = (state_q != st_idle);

   // Two flops on every bus and strap pin before any logic reads it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
         strap_lo_s1_q <= STRAP_GND;
         strap_lo_s2_q <= STRAP_GND;
         strap_hi_s1_q <= STRAP_GND;
         strap_hi_s2_q <= STRAP_GND;
      end else begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
         strap_lo_s1_q <= address_strap_low;
         strap_lo_s2_q <= strap_lo_s1_q;
         strap_hi_s1_q <= address_strap_high;
         strap_hi_s2_q <= strap_hi_s1_q;
      end
   end

   // Protocol next state; start and stop override everything
   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      shift_d = shift_q;
      tx_d = tx_q;
      idx_d = idx_q;
      hold_d = hold_q;
      sda_low_d = sda_low_q;
      rw_d = rw_q;
      nack_d = nack_q;
      lsb_d = lsb_q;
      ptr_d = ptr_q;
      cfg_d = cfg_q;
      cal_d = cal_q;
      my_addr_d = my_addr_q;
      if (start_det) begin
         // Also a repeated start, which ends any read or write
         state_d = st_addr;
         bit_d = 4'h0;
         sda_low_d = 1'b0;
         my_addr_d = strap_addr;
      end else if (stop_det || tmo_hit) begin
         state_d = st_idle;
         sda_low_d = 1'b0;
      end else begin
         // Data sampled on the clock rise only
         if (scl_rise && shifting && !byte_end) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            bit_d = bit_q + 4'h1;
         end
         if (scl_rise && state_q == st_tx_ack) begin
            nack_d = sda_s2_q;
         end
         // Outputs change only while the clock is low
         if (scl_fall) begin
            unique case (state_q)
               st_addr: if (byte_end) begin
                  // Seven address bits, then the direction bit
                  if (shift_q[7:1] == my_addr_q) begin
                     state_d = st_addr_ack;
                     sda_low_d = 1'b1;
                     rw_d = shift_q[0];
                  end else begin
                     state_d = st_idle;
                  end
               end
               st_addr_ack: begin
                  bit_d = 4'h0;
                  if (rw_q) begin
                     state_d = st_tx;
                     tx_d = rd_word[15:8];
                     sda_low_d = ~rd_word[15];
                     lsb_d = 1'b1;
                  end else begin
                     state_d = st_rx;
                     idx_d = IDX_PTR;
                     sda_low_d = 1'b0;
                  end
               end
               st_rx: if (byte_end) begin
                  // Every received byte is acknowledged
                  state_d = st_rx_ack;
                  sda_low_d = 1'b1;
                  unique case (idx_q)
                     IDX_PTR: ptr_d = shift_q;
                     IDX_MSB: hold_d = shift_q;
                     IDX_LSB: begin
                        if (ptr_q == PTR_CONFIG) begin
                           cfg_d = wr_word;
                           if (wr_word[CONFIG_RST_BIT]) begin
                              cfg_d = CONFIG_RESET;
                              cal_d = CAL_RESET;
                           end
                        end
                        if (ptr_q == PTR_CAL) begin
                           cal_d = wr_word;
                        end
                     end
                     IDX_DONE: ;                     // Extra bytes dropped
                  endcase
                  if (idx_q != IDX_DONE) begin
                     idx_d = idx_q + 2'h1;
                  end
               end
               st_rx_ack: begin
                  // A pointer-only write returns to st_rx and waits for stop there
                  state_d = st_rx;
                  bit_d = 4'h0;
                  sda_low_d = 1'b0;
               end
               st_tx: if (byte_end) begin
                  state_d = st_tx_ack;
                  sda_low_d = 1'b0;
               end else begin
                  tx_d = {tx_q[6:0], 1'b0};
                  sda_low_d = ~tx_q[6];
               end
               st_tx_ack: if (nack_q) begin
                  state_d = st_idle;
               end else begin
                  // Further acks alternate high and low bytes
                  state_d = st_tx;
                  bit_d = 4'h0;
                  tx_d = lsb_q ? rd_word[7:0] : rd_word[15:8];
                  sda_low_d = lsb_q ? ~rd_word[7] : ~rd_word[15];
                  lsb_d = ~lsb_q;
               end
               st_idle: ;
            endcase
         end
      end
   end

   // Protocol and register state; all volatile, reset at power-up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= st_idle;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         idx_q <= IDX_PTR;
         hold_q <= 8'h00;
         sda_low_q <= 1'b0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         lsb_q <= 1'b0;
         my_addr_q <= {ADDR_FIXED, STRAP_GND, STRAP_GND};
         ptr_q <= PTR_RESET;
         cfg_q <= CONFIG_RESET;
         cal_q <= CAL_RESET;
      end else begin
         state_q <= state_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         idx_q <= idx_d;
         hold_q <= hold_d;
         sda_low_q <= sda_low_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         lsb_q <= lsb_d;
         my_addr_q <= my_addr_d;
         ptr_q <= ptr_d;
         cfg_q <= cfg_d;
         cal_q <= cal_d;
      end
   end

   // Results held at zero while calibration is unset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         current_q <= 16'h0000;
         power_q <= 16'h0000;
      end else if (cal_zero) begin
         current_q <= 16'h0000;
         power_q <= 16'h0000;
      end else begin
         current_q <= cur_next;
         power_q <= pow_quot[15:0];
      end
   end

   // Lockup timer: restarts on every clock edge of the bus.
   // At 10 MHz the top HS rate leaves very short high phases, so a
   // 2.94 MHz clock only works if each phase spans two sample edges.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tmo_q <= '0;
      end else if (state_q == st_idle || scl_rise || scl_fall) begin
         tmo_q <= '0;
      end else begin
         tmo_q <= tmo_q + TMO_W'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_start_to_addr:
      assert property (start_det |=> state_q == st_addr && !sda_low_q)
      else $error("start did not begin an address byte");
   a_stop_to_idle:
      assert property (stop_det && !start_det |=> state_q == st_idle)
      else $error("stop did not end the transaction");
   a_addr_ack_low:
      assert property (state_q == st_addr_ack |-> sda_low_q)
      else $error("address ack not driven low");
   a_addr_mismatch:
      assert property (scl_fall && state_q == st_addr && byte_end &&
         shift_q[7:1] != my_addr_q && !start_det && !stop_det
         |=> state_q == st_idle && !sda_low_q)
      else $error("foreign address was answered");
   a_timeout_release:
      assert property (tmo_hit && !start_det |=> state_q == st_idle
         ##1 !sda_low_q)
      else $error("timeout did not release the bus");
   a_pointer_load:
      assert property (scl_fall && state_q == st_rx && byte_end &&
         idx_q == IDX_PTR && !start_det && !stop_det && !tmo_hit
         |=> ptr_q == $past(shift_q))
      else $error("pointer byte not loaded");
   a_pointer_hold:
      assert property (state_q != st_rx |=> $stable(ptr_q))
      else $error("pointer changed outside a write");
   a_uncal_zero:
      assert property (cal_zero [*2] |-> current_q == 16'h0000 &&
         power_q == 16'h0000)
      else $error("result nonzero without calibration");
   a_current_scale:
      assert property (!cal_zero |=> current_q == $past(cur_next))
      else $error("current result not scaled");
   a_tx_msb_first:
      assert property (scl_fall && state_q == st_addr_ack && rw_q &&
         !start_det && !stop_det && !tmo_hit
         |=> tx_q == $past(rd_word[15:8]) && sda_low_q == ~tx_q[7])
      else $error("read did not start with high byte");
endmodule

// *** test/bus_master_model.sv ***
// Behavioural two-wire bus master facing the monitor slave port
`timescale 1ns/10ps
module bus_master_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl_out,
   output logic sda_low
);
   // Idle bus: clock high, data left to the pull-up
   initial begin
      scl_out = 1'b1;
      sda_low = 1'b0;
   end

   // Quarter of an 800 ns bus period, moves on the falling clock edge
   task automatic quarter();
      repeat (2) @(negedge clk);
   endtask

   // Start or repeated start; waits first so a slave ack can drop
   task automatic start();
      repeat (2) quarter();
      sda_low = 1'b0;
      quarter();
      scl_out = 1'b1;
      quarter();
      sda_low = 1'b1;
      quarter();
      scl_out = 1'b0;
   endtask

   // Stop from a low clock, bus left idle
   task automatic stop();
      quarter();
      sda_low = 1'b1;
      quarter();
      scl_out = 1'b1;
      quarter();
      sda_low = 1'b0;
      quarter();
   endtask

   // One bit: data set mid-low, held through the whole high phase
   task automatic bit_xfer(input logic b, output logic r);
      quarter();
      sda_low = ~b;
      quarter();
      scl_out = 1'b1;
      quarter();
      r = sda_line;
      quarter();
      scl_out = 1'b0;
   endtask

   // Eight bits then the acknowledge slot; a 1 releases the line
   task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
      output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], q[i]);
      end
      bit_xfer(ack_in, ack);
   endtask
endmodule

// *** test/monitor_serial_slave_port_tb.sv ***
// Self-checking bench for the monitor serial slave port
`timescale 1ns/10ps
`define CHK(g, e) \
   begin \
      n_tests++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("[FAIL] %0t: got %h, expected %h", $time, (g), (e)); \
      end \
   end
module monitor_serial_slave_port_tb
   import monitor_serial_pkg::*;
();
   localparam int TO = 200; // Short lockup count keeps the run brief
   logic clk;
   logic reset_n;
   logic scl;
   logic sda_low;
   logic sda_line;
   logic sda_out;
   logic sda_oe_n;
   logic [1:0] address_strap_low;
   logic [1:0] address_strap_high;
   logic [15:0] shunt_voltage;
   logic [15:0] bus_voltage;
   logic [15:0] config_word;
   logic busy;
   logic [6:0] adr; // Address the straps currently select
   logic [31:0] seed = 32'h0000_0AA8;
   int miscompares = 0;
   int n_tests = 0;

   // Open-drain data wire with pull-up
   assign sda_line = ~(sda_low | (~sda_oe_n & ~sda_out));

   monitor_serial_slave_port #(.TIMEOUT_CYCLES(TO)) u_dut (
      .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .address_strap_low(address_strap_low),
      .address_strap_high(address_strap_high),
      .shunt_voltage(shunt_voltage), .bus_voltage(bus_voltage),
      .config_word(config_word), .busy(busy));

   bus_master_model u_m (.clk(clk), .sda_line(sda_line), .scl_out(scl),
      .sda_low(sda_low));

   // 10 MHz system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Xorshift source, fixed seed so runs repeat
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Signed shunt times calibration, arithmetic divide by 2048
   function automatic logic [15:0] exp_cur(logic [15:0] s, logic [15:0] c);
      logic signed [33:0] p;
      p = $signed(s) * $signed({1'b0, c});
      return p[26:11];
   endfunction

   // Magnitude of current times bus voltage over 20000
   function automatic logic [15:0] exp_pwr(logic [15:0] i, logic [15:0] b);
      logic [15:0] m;
      m = i[15] ? -i : i;
      return 16'((32'(m) * 32'(b)) / POWER_DIV);
   endfunction

   // Address byte only, then stop
   task automatic probe(input logic [6:0] x, output logic a);
      logic [7:0] q;
      u_m.start();
      u_m.byte_xfer({x, 1'b0}, 1'b1, q, a);
      u_m.stop();
   endtask

   // Write phase that loads the pointer, left open
   task automatic sel(input logic [7:0] p);
      logic [7:0] q;
      logic a;
      u_m.start();
      u_m.byte_xfer({adr, 1'b0}, 1'b1, q, a);
      `CHK(a, 1'b0)
      u_m.byte_xfer(p, 1'b1, q, a);
      `CHK(a, 1'b0)
   endtask

   // Full word write, high byte first
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      logic [7:0] q;
      logic a;
      sel(p);
      u_m.byte_xfer(d[15:8], 1'b1, q, a);
      `CHK(a, 1'b0)
      u_m.byte_xfer(d[7:0], 1'b1, q, a);
      `CHK(a, 1'b0)
      u_m.stop();
   endtask

   // Word read, optionally after a pointer write and repeated start
   task automatic rd(input logic [7:0] p, input logic setp,
      output logic [15:0] v);
      logic [7:0] q;
      logic a;
      if (setp) begin
         sel(p);
      end
      u_m.start();
      u_m.byte_xfer({adr, 1'b1}, 1'b1, q, a);
      `CHK(a, 1'b0)
      u_m.byte_xfer(8'hFF, 1'b0, v[15:8], a);
      u_m.byte_xfer(8'hFF, 1'b1, v[7:0], a);
      u_m.stop();
   endtask

   // Verdict and end of run
   task end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog, about twice the expected run length
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      end_of_test();
   end

   // Main sequence
   initial begin
      logic [15:0] v;
      logic [15:0] cal;
      logic [15:0] c;
      logic [31:0] r;
      logic [7:0] q;
      logic a;
      reset_n = 1'b0;
      address_strap_low = 2'h0;
      address_strap_high = 2'h0;
      shunt_voltage = 16'h1F40;
      bus_voltage = 16'h2570;
      adr = {ADDR_FIXED, 4'h0};
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(config_word, CONFIG_RESET)
      `CHK(sda_oe_n, 1'b1)
      `CHK(sda_out, 1'b0)
      `CHK(busy, 1'b0)
      rd(8'h00, 1'b0, v);
      `CHK(v, CONFIG_RESET)
      // Every strap combination, each neighbour address refused
      for (int k = 0; k < 16; k++) begin
         address_strap_high = k[3:2];
         address_strap_low = k[1:0];
         adr = {ADDR_FIXED, k[3:0]};
         probe(adr ^ 7'h01, a);
         `CHK(a, 1'b1)
         probe(adr, a);
         `CHK(a, 1'b0)
      end
      r = rnd();
      address_strap_high = r[3:2];
      address_strap_low = r[1:0];
      adr = {ADDR_FIXED, r[3:0]};
      // Results stay zero while calibration is unset
      rd(PTR_CURRENT, 1'b1, v);
      `CHK(v, 16'h0000)
      rd(PTR_POWER, 1'b1, v);
      `CHK(v, 16'h0000)
      // Documented example, its negative twin, then random values
      for (int n = 0; n < 6; n++) begin
         if (n > 1) begin
            shunt_voltage = 16'(rnd()) & 16'h0FFF;
            bus_voltage = 16'(rnd()) & 16'h7FFF;
         end
         shunt_voltage = (n == 1) ? 16'hE0C0 : shunt_voltage;
         cal = (n < 2) ? 16'h0A00 : 16'(rnd()) & 16'h0FFF;
         wr(PTR_CAL, cal);
         rd(PTR_CAL, 1'b1, v);
         `CHK(v, cal)
         rd(PTR_CURRENT, 1'b1, v);
         `CHK(v, exp_cur(shunt_voltage, cal))
         c = exp_pwr(exp_cur(shunt_voltage, cal), bus_voltage);
         rd(PTR_POWER, 1'b1, v);
         `CHK(v, c)
         rd(8'h00, 1'b0, v);
         `CHK(v, c)
      end
      // Host trims calibration from an ammeter reading
      shunt_voltage = 16'h1F40;
      wr(PTR_CAL, 16'h0A00);
      rd(PTR_CURRENT, 1'b1, v);
      `CHK(v, 16'h2710)
      r = 32'h0A00 * (32'h2710 + (rnd() & 32'h0000_03FF)) / 32'(v);
      cal = r[15:0];
      wr(PTR_CAL, cal);
      rd(PTR_CURRENT, 1'b1, v);
      `CHK(v, exp_cur(shunt_voltage, cal))
      // Acked low byte wraps the read back to the high byte
      sel(PTR_SHUNT);
      u_m.start();
      u_m.byte_xfer({adr, 1'b1}, 1'b1, q, a);
      u_m.byte_xfer(8'hFF, 1'b0, v[15:8], a);
      u_m.byte_xfer(8'hFF, 1'b0, v[7:0], a);
      `CHK(v, shunt_voltage)
      u_m.byte_xfer(8'hFF, 1'b1, q, a);
      `CHK(q, shunt_voltage[15:8])
      u_m.stop();
      rd(PTR_BUS, 1'b1, v);
      `CHK(v, bus_voltage)
      // Pointer-only write closed by stop, then a bare read
      sel(PTR_CAL);
      u_m.stop();
      rd(8'h00, 1'b0, v);
      `CHK(v, cal)
      // Power cycle mid-run: pointer and calibration return to reset values
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(config_word, CONFIG_RESET)
      `CHK(busy, 1'b0)
      rd(8'h00, 1'b0, v);
      `CHK(v, CONFIG_RESET)
      rd(PTR_CURRENT, 1'b1, v);
      `CHK(v, 16'h0000)
      // Calibration back in place so the reset bit can clear it
      wr(PTR_CAL, cal);
      c = 16'(rnd()) & 16'h7FFF;
      wr(PTR_CONFIG, c);
      `CHK(config_word, c)
      wr(PTR_CONFIG, 16'h8000);
      `CHK(config_word, CONFIG_RESET)
      rd(PTR_CURRENT, 1'b1, v);
      `CHK(v, 16'h0000)
      // Not-acknowledge after the high byte ends the read at once
      sel(PTR_CONFIG);
      u_m.start();
      u_m.byte_xfer({adr, 1'b1}, 1'b1, q, a);
      `CHK(a, 1'b0)
      u_m.byte_xfer(8'hFF, 1'b1, q, a);
      repeat (6) @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(q, CONFIG_RESET[15:8])
      u_m.stop();
      // Stall with the clock low while the address ack is held
      u_m.start();
      for (int i = 6; i >= 0; i--) begin
         u_m.bit_xfer(adr[i], a);
      end
      u_m.bit_xfer(1'b0, a);
      repeat (6) @(negedge clk);
      `CHK(sda_oe_n, 1'b0)
      repeat (TO + 20) @(negedge clk);
      `CHK(sda_oe_n, 1'b1)
      `CHK(busy, 1'b0)
      u_m.stop();
      end_of_test();
   end
endmodule
